//--- tcc_core.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tcc_core (
	// Clock, reset, enable
	input  wire logic                          CLK_IN,
	input  wire logic                          RST_B_IN,
	input  wire logic                          CE_IN,
	// APB slave
	input  wire logic                          PSEL_IN,
	input  wire logic                          PENABLE_IN,
	input  wire logic                          PWRITE_IN,
	input  wire logic [tcc_pkg::TCC_AW-1:0]    PADDR_IN,
	input  wire logic [tcc_pkg::TCC_DW-1:0]    PWDATA_IN,
	output logic      [tcc_pkg::TCC_DW-1:0]    PRDATA_OUT,
	output logic                               PREADY_OUT,
	output logic                               PSLVERR_OUT,
	// Counter clock sources and synchronization
	input  wire logic                          FIXED_CLK_IN,
	input  wire logic                          EXT_CLK_IN,
	input  wire logic                          SYNC_IN,
	// Counter state
	output logic      [tcc_pkg::TCC_CW-1:0]    COUNT_OUT,
	output logic                               OVERFLOW_FLAG_OUT,
	output logic                               CH_INIT_OUT
);
	import tcc_pkg::*;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	tcc_apb_req_t req;
	logic         pready_q;
	wire          acc_done = req.sel & req.en & pready_q;
	wire          wr_acc   = acc_done & req.wr;
	wire          setup    = req.sel & ~req.en;
	wire          hit_ctrl = (req.addr == TCC_CTRL_OFS);
	wire          hit_stat = (req.addr == TCC_STATUS_OFS);
	wire          hit_cnt  = (req.addr == TCC_COUNT_OFS);
	wire          hit_init = (req.addr == TCC_INIT_OFS);
	wire          hit_mod  = (req.addr == TCC_MOD_OFS);
	wire          hit_any  = hit_ctrl | hit_stat | hit_cnt | hit_init | hit_mod;

	assign req = '{sel: PSEL_IN, en: PENABLE_IN, wr: PWRITE_IN, addr: PADDR_IN, wdata: PWDATA_IN};

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	tcc_ctrl_t         ctrl_q;
	logic [TCC_CW-1:0] init_q;
	logic [TCC_CW-1:0] mod_q;
	logic [TCC_CW-1:0] cnt_q;
	logic [TCC_CW-1:0] cnt_d;
	tcc_dir_t          dir_q;
	tcc_dir_t          dir_d;
	logic              flag_q;
	logic [4:0]        ovc_q;
	logic [6:0]        pre_q;
	logic [TCC_DW-1:0] prdata_q;
	logic              pslverr_q;
	logic              ch_init_q;
	logic              fix_prev_q;
	logic              ext_s1_q;
	logic              ext_s2_q;
	logic              ext_s3_q;

	wire ctrl_wr  = CE_IN & wr_acc & hit_ctrl;
	wire stat_clr = CE_IN & wr_acc & hit_stat & req.wdata[TCC_FLAG_BIT];
	wire cnt_wr   = CE_IN & wr_acc & hit_cnt;
	wire init_wr  = CE_IN & wr_acc & hit_init;
	wire mod_wr   = CE_IN & wr_acc & hit_mod;
	wire reload   = cnt_wr | (CE_IN & SYNC_IN);

	// ----------------------------------------------------------------
	// Counter clock source and prescaler
	// ----------------------------------------------------------------
	wire       fix_edge = FIXED_CLK_IN & ~fix_prev_q;
	wire       ext_edge = ext_s2_q & ~ext_s3_q;
	wire       src_tick = (ctrl_q.counter_clock_select == TCC_CLK_SYS) |
	                      ((ctrl_q.counter_clock_select == TCC_CLK_FIX) & fix_edge) |
	                      ((ctrl_q.counter_clock_select == TCC_CLK_EXT) & ext_edge);
	wire [6:0] pre_mask = 7'((8'h01 << ctrl_q.prescale_select) - 8'h01);
	wire       pre_wrap = ((pre_q & pre_mask) == pre_mask);
	wire       cnt_tick = CE_IN & src_tick & pre_wrap & ~reload;

	// ----------------------------------------------------------------
	// Counting modes
	// ----------------------------------------------------------------
	wire ext_en    = ctrl_q.extended_features_enable;
	wire center    = ctrl_q.center_align_select;
	wire mod_edge  = (mod_q == TCC_CNT_RST) | (mod_q == TCC_CNT_MAX);
	wire free_run  = (~ext_en & mod_edge) |
	                 (ext_en & ~center & (init_q == TCC_CNT_RST) & (mod_q == TCC_CNT_MAX));
	wire stop_zero = ext_en & (mod_q == TCC_CNT_RST) & (init_q == TCC_CNT_RST);
	wire is_signed = init_q[TCC_SIGN_BIT];
	wire at_mod    = (cnt_q == mod_q);
	wire past_mod  = is_signed ? ($signed(cnt_q) >= $signed(mod_q)) : (cnt_q >= mod_q);
	wire past_init = is_signed ? ($signed(cnt_q) <= $signed(init_q)) : (cnt_q <= init_q);
	logic [TCC_CW-1:0] cnt_plus;
	logic [TCC_CW-1:0] cnt_minus;
	logic              ovf_evt;

	assign cnt_plus  = 16'(cnt_q + TCC_CNT_ONE);
	assign cnt_minus = 16'(cnt_q - TCC_CNT_ONE);

	always_comb begin
		cnt_d   = cnt_q;
		dir_d   = dir_q;
		ovf_evt = 1'b0;
		if (reload) begin
			cnt_d = init_q;
			dir_d = TCC_DIR_UP;
		end else if (cnt_tick) begin
			if (stop_zero) begin
				cnt_d = TCC_CNT_RST;
			end else if (free_run) begin
				cnt_d   = cnt_plus;
				ovf_evt = (cnt_q == TCC_CNT_MAX);
			end else if (!center) begin
				if (at_mod) begin
					cnt_d   = init_q;
					ovf_evt = 1'b1;
				end else begin
					cnt_d = cnt_plus;
				end
			end else if (mod_q == init_q) begin
				cnt_d   = mod_q;
				ovf_evt = 1'b1;
			end else if (dir_q == TCC_DIR_UP) begin
				if (past_mod) begin
					cnt_d   = cnt_minus;
					dir_d   = TCC_DIR_DOWN;
					ovf_evt = at_mod;
				end else begin
					cnt_d = cnt_plus;
				end
			end else begin
				if (past_init) begin
					cnt_d = cnt_plus;
					dir_d = TCC_DIR_UP;
				end else begin
					cnt_d = cnt_minus;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Overflow spacing
	// ----------------------------------------------------------------
	wire ovf_hit  = ovf_evt & (ovc_q >= ctrl_q.overflow_count_field);
	wire flag_set = CE_IN & ovf_hit;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [TCC_DW-1:0] rd_mux;

	assign rd_mux = hit_ctrl ? {20'h00000, ctrl_q} :
	                hit_stat ? {31'h00000000, flag_q} :
	                hit_cnt  ? {16'h0000, cnt_q} :
	                hit_init ? {16'h0000, init_q} :
	                hit_mod  ? {16'h0000, mod_q} : 32'h00000000;

	// ----------------------------------------------------------------
	// Flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pready_q  <= 1'b0;
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else if (CE_IN) begin
			pready_q  <= req.sel & req.en & ~pready_q;
			pslverr_q <= req.sel & req.en & ~pready_q & ~hit_any;
			if (setup) begin
				prdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctrl_q <= TCC_CTRL_RST;
			init_q <= TCC_INIT_RST;
			mod_q  <= TCC_MOD_RST;
		end else begin
			if (ctrl_wr) begin
				ctrl_q <= tcc_ctrl_t'(req.wdata[TCC_CTRL_W-1:0]);
			end
			if (init_wr) begin
				init_q <= req.wdata[TCC_CW-1:0];
			end
			if (mod_wr) begin
				mod_q <= req.wdata[TCC_CW-1:0];
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			cnt_q     <= TCC_CNT_RST;
			dir_q     <= TCC_DIR_UP;
			ch_init_q <= 1'b0;
		end else if (CE_IN) begin
			cnt_q     <= cnt_d;
			dir_q     <= dir_d;
			ch_init_q <= reload;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pre_q <= TCC_PRE_RST;
		end else if (reload) begin
			pre_q <= TCC_PRE_RST;
		end else if (CE_IN & src_tick) begin
			pre_q <= pre_wrap ? TCC_PRE_RST : 7'(pre_q + 7'h01);
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			flag_q <= 1'b0;
			ovc_q  <= TCC_OVC_RST;
		end else begin
			if (flag_set) begin
				flag_q <= 1'b1;
			end else if (stat_clr) begin
				flag_q <= 1'b0;
			end
			if (cnt_wr | flag_set) begin
				ovc_q <= TCC_OVC_RST;
			end else if (CE_IN & ovf_evt) begin
				ovc_q <= 5'(ovc_q + 5'h01);
			end
		end
	end

	// Synchroniser and edge detectors, all in the system clock domain
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			fix_prev_q <= 1'b0;
			ext_s1_q   <= 1'b0;
			ext_s2_q   <= 1'b0;
			ext_s3_q   <= 1'b0;
		end else if (CE_IN) begin
			fix_prev_q <= FIXED_CLK_IN;
			ext_s1_q   <= EXT_CLK_IN;
			ext_s2_q   <= ext_s1_q;
			ext_s3_q   <= ext_s2_q;
		end
	end

	assign PRDATA_OUT        = prdata_q;
	assign PREADY_OUT        = pready_q;
	assign PSLVERR_OUT       = pslverr_q;
	assign COUNT_OUT         = cnt_q;
	assign OVERFLOW_FLAG_OUT = flag_q;
	assign CH_INIT_OUT       = ch_init_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	a_hold_no_src: assert property ((CE_IN && ctrl_q.counter_clock_select == TCC_CLK_NONE && !reload)
		|=> $stable(cnt_q)) else $error("Counter moved with no clock source");

	a_up_reload: assert property ((cnt_tick && !center && !free_run && !stop_zero && at_mod)
		|=> (cnt_q == $past(init_q))) else $error("Up counter did not reload initial value");

	a_ud_turn: assert property ((cnt_tick && center && !free_run && !stop_zero && at_mod
		&& dir_q == TCC_DIR_UP && mod_q != init_q)
		|=> (cnt_q == 16'($past(mod_q) - TCC_CNT_ONE)) && dir_q == TCC_DIR_DOWN)
		else $error("Up-down counter did not turn at modulo");

	a_free_wrap: assert property ((cnt_tick && free_run && !stop_zero && cnt_q == TCC_CNT_MAX)
		|=> (cnt_q == TCC_CNT_RST)) else $error("Free counter did not wrap to zero");

	a_zero_stop: assert property ((CE_IN && stop_zero && cnt_q == TCC_CNT_RST && !reload
		&& !init_wr && !mod_wr) |=> (cnt_q == TCC_CNT_RST)) else $error("Counter left zero while stopped");

	a_cnt_write: assert property (cnt_wr |=> (cnt_q == $past(init_q)) && ch_init_q)
		else $error("Count write did not reload initial value");

	a_flag_every: assert property ((flag_set) |=> flag_q)
		else $error("Overflow flag not set on qualifying overflow");

	a_ovf_space: assert property ((CE_IN && ovf_evt && !cnt_wr && ovc_q < ctrl_q.overflow_count_field)
		|=> (ovc_q == 5'($past(ovc_q) + 5'h01)) && $stable(flag_q) || $past(stat_clr))
		else $error("Overflow spacing counter misbehaved");

	a_presc_half: assert property ((CE_IN && ctrl_q.counter_clock_select == TCC_CLK_SYS
		&& ctrl_q.prescale_select == 3'h1 && cnt_tick && !ctrl_wr) |=> !cnt_tick)
		else $error("Divide by two prescaler ticked twice in a row");

	a_ext_sync: assert property ((CE_IN && ctrl_q.counter_clock_select == TCC_CLK_EXT && src_tick)
		|-> $past(EXT_CLK_IN, 2) && !$past(EXT_CLK_IN, 3)) else $error("External tick not from synchronised edge");

	c_up_overflow:   cover property (cnt_tick && !center && at_mod && flag_set);
	c_ud_overflow:   cover property (cnt_tick && center && at_mod && ovf_evt);
	c_free_wrap:     cover property (cnt_tick && free_run && cnt_q == TCC_CNT_MAX);
	c_spaced_flag:   cover property (flag_set && ctrl_q.overflow_count_field != 5'h00);

endmodule

//--- tcc_pkg.sv
package tcc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int TCC_AW = 8;
	localparam int TCC_DW = 32;
	localparam int TCC_CW = 16;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [TCC_AW-1:0] TCC_CTRL_OFS   = 8'h00;
	localparam logic [TCC_AW-1:0] TCC_STATUS_OFS = 8'h04;
	localparam logic [TCC_AW-1:0] TCC_COUNT_OFS  = 8'h08;
	localparam logic [TCC_AW-1:0] TCC_INIT_OFS   = 8'h0c;
	localparam logic [TCC_AW-1:0] TCC_MOD_OFS    = 8'h10;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int TCC_CTRL_W   = 12;
	localparam int TCC_FLAG_BIT = 0;
	localparam int TCC_SIGN_BIT = 15;

	// ----------------------------------------------------------------
	// Counter clock select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] TCC_CLK_NONE = 2'h0;
	localparam logic [1:0] TCC_CLK_SYS  = 2'h1;
	localparam logic [1:0] TCC_CLK_FIX  = 2'h2;
	localparam logic [1:0] TCC_CLK_EXT  = 2'h3;

	// ----------------------------------------------------------------
	// Control word, low bits of the control register
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] overflow_count_field;
		logic       extended_features_enable;
		logic       center_align_select;
		logic [2:0] prescale_select;
		logic [1:0] counter_clock_select;
	} tcc_ctrl_t;

	// ----------------------------------------------------------------
	// Internal bus request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              sel;
		logic              en;
		logic              wr;
		logic [TCC_AW-1:0] addr;
		logic [TCC_DW-1:0] wdata;
	} tcc_apb_req_t;

	typedef enum logic {TCC_DIR_UP, TCC_DIR_DOWN} tcc_dir_t;

	// ----------------------------------------------------------------
	// Reset values and counter constants
	// ----------------------------------------------------------------
	localparam tcc_ctrl_t         TCC_CTRL_RST = '0;
	localparam logic [TCC_CW-1:0] TCC_INIT_RST = 16'h0000;
	localparam logic [TCC_CW-1:0] TCC_MOD_RST  = 16'h0000;
	localparam logic [TCC_CW-1:0] TCC_CNT_RST  = 16'h0000;
	localparam logic [TCC_CW-1:0] TCC_CNT_MAX  = 16'hffff;
	localparam logic [TCC_CW-1:0] TCC_CNT_ONE  = 16'h0001;
	localparam logic [6:0]        TCC_PRE_RST  = 7'h00;
	localparam logic [4:0]        TCC_OVC_RST  = 5'h00;

endpackage

//--- tb.sv
`timescale 1ns/1ps
module tb;
	import tcc_pkg::*;
	// ----------------------------------------------------------------
	// Signals and bench state
	// ----------------------------------------------------------------
	logic        clk, rst_b, psel, pen, pwr, fix, ext, sync, prdy, perr, fl_o, chi, cen;
	logic [7:0]  padr;
	logic [31:0] pwd, prd;
	logic [15:0] cnt_o, pcnt, ini, mo, cnt, lastv;
	logic [2:0]  ps;
	logic [1:0]  src;
	logic [4:0]  nt;
	logic        ca, fte, dn, fl, pfl, chk_on;
	logic [23:0] ce;
	logic [33:0] re;
	logic [23:0] cq[$];
	logic [33:0] rq[$];
	int          fq[$];
	int          num_errors, tests_run, chg_n, gap, ch_n, chx, nchg, ovc, pre, i, m, n;

	tcc_core i_dut (
		.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(cen),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd),
		.PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
		.FIXED_CLK_IN(fix), .EXT_CLK_IN(ext), .SYNC_IN(sync),
		.COUNT_OUT(cnt_o), .OVERFLOW_FLAG_OUT(fl_o), .CH_INIT_OUT(chi)
	);

	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Output watcher: takes the oldest note whenever a result shows
	// ----------------------------------------------------------------
	always @(negedge clk) begin
		gap++;
		if (rst_b && cnt_o !== pcnt) begin
			if (chk_on) begin
				chg_n++;
				if (cq.size() == 0)
					cmp("count", 32'h1ffff, {16'h0, cnt_o});
				else begin
					ce = cq.pop_front();
					cmp("count", {16'h0, ce[15:0]}, {16'h0, cnt_o});
					if (ce[23:16] != 0)
						cmp("tick spacing", {24'h0, ce[23:16]}, gap);
				end
			end
			gap = 0;
		end
		pcnt = cnt_o;
		if (fl_o === 1'b1 && pfl !== 1'b1)
			cmp("flag position", fq.size() ? fq.pop_front() : -1, chg_n);
		pfl = fl_o;
		if (chi === 1'b1)
			ch_n++;
		if (psel && pen && prdy === 1'b1) begin
			re = rq.pop_front();
			cmp("slverr", {31'h0, re[32]}, {31'h0, perr});
			if (!re[33])
				cmp("rdata", re[31:0], prd);
		end
	end

	// ----------------------------------------------------------------
	// Bus master and counter model
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er = 1'b0);
		@(posedge clk);
		rq.push_back({w, er, d});
		psel <= 1'b1;
		pen  <= 1'b0;
		pwr  <= w;
		padr <= a;
		pwd  <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(negedge clk);
		end while (prdy !== 1'b1);
		@(posedge clk);
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	function automatic void note(input logic [15:0] v, input logic [7:0] g);
		if (v !== lastv) begin
			cq.push_back({g, v});
			nchg++;
			lastv = v;
		end
	endfunction

	function automatic void step(input logic [7:0] g);
		logic ov;
		ov = 1'b0;
		if (fte && mo == 0 && ini == 0)
			ov = 1'b0;
		else if ((!fte && (mo == 0 || mo == 16'hffff)) || (fte && !ca && ini == 0 && mo == 16'hffff)) begin
			ov = cnt == 16'hffff;
			cnt++;
		end else if (mo == ini) begin
			cnt = mo;
			ov = 1'b1;
		end else if (cnt == mo) begin
			cnt = ca ? cnt - 16'h1 : ini;
			dn = ca;
			ov = 1'b1;
		end else if (dn && cnt == ini) begin
			cnt++;
			dn = 1'b0;
		end else if (dn)
			cnt--;
		else
			cnt++;
		note(cnt, g);
		if (ov && ovc >= nt) begin
			ovc = 0;
			if (!fl)
				fq.push_back(nchg);
			fl = 1'b1;
		end else if (ov)
			ovc++;
	endfunction

	task automatic tk(input int k);
		int h;
		h = (src == TCC_CLK_EXT) ? 4 : 1;
		repeat (k) begin
			@(posedge clk);
			if (src == TCC_CLK_EXT) ext <= 1'b1; else fix <= 1'b1;
			// Note goes in before the synchronised edge can move the counter
			if (src != TCC_CLK_NONE) begin
				pre++;
				if (pre == (1 << ps)) begin
					pre = 0;
					step(8'h0);
				end
			end
			repeat (h) @(posedge clk);
			ext <= 1'b0;
			fix <= 1'b0;
			repeat (h - 1) @(posedge clk);
		end
	endtask

	task automatic cfg(input logic [1:0] s, input logic [2:0] p, input logic c, input logic f, input logic [4:0] k);
		src = s;
		ps  = p;
		ca  = c;
		fte = f;
		nt  = k;
		apb(1'b1, TCC_CTRL_OFS, {20'h0, tcc_ctrl_t'{k, f, c, p, s}});
	endtask

	task automatic setv(input logic [15:0] a, input logic [15:0] b);
		ini = a;
		mo  = b;
		apb(1'b1, TCC_INIT_OFS, {16'h0, a});
		apb(1'b1, TCC_MOD_OFS, {16'h0, b});
	endtask

	task automatic wcount();
		cnt = ini;
		dn  = 1'b0;
		ovc = 0;
		pre = 0;
		chx++;
		note(cnt, 8'h0);
		apb(1'b1, TCC_COUNT_OFS, 32'h0);
	endtask

	task automatic clr();
		fl = 1'b0;
		apb(1'b1, TCC_STATUS_OFS, 32'h1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, pen, pwr, fix, ext, sync, rst_b, padr, pwd} = '0;
		{num_errors, tests_run, chg_n, gap, ch_n, chx, nchg, ovc, pre} = '0;
		{pcnt, lastv, cnt, ini, mo, ps, src, nt, ca, fte, dn, fl, pfl} = '0;
		chk_on = 1'b1;
		cen    = 1'b1;
		void'($urandom(32'h7c75));
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, TCC_CTRL_OFS, 32'h0);
		apb(1'b0, TCC_STATUS_OFS, 32'h0);
		apb(1'b0, TCC_COUNT_OFS, 32'h0);
		apb(1'b0, TCC_INIT_OFS, 32'h0);
		apb(1'b0, TCC_MOD_OFS, 32'h0);
		apb(1'b0, 8'h14, 32'h0, 1'b1);
		apb(1'b1, 8'h18, 32'h5a, 1'b1);
		i = $urandom % 8;
		m = i + 2 + $urandom % 6;
		setv(i[15:0], m[15:0]);
		cfg(TCC_CLK_FIX, 3'h0, 1'b0, 1'b0, 5'h0);
		clr();
		wcount();
		tk(2 * (m - i) + 3);
		setv(16'hfffc, 16'h0004);
		cfg(TCC_CLK_FIX, 3'h1, 1'b0, 1'b0, 5'h0);
		clr();
		wcount();
		tk(24);
		cfg(TCC_CLK_NONE, 3'h1, 1'b0, 1'b0, 5'h0);
		tk(4);
		apb(1'b0, TCC_COUNT_OFS, {16'h0, cnt});
		apb(1'b0, TCC_MOD_OFS, {16'h0, mo});
		setv(16'h0001, 16'h0004);
		cfg(TCC_CLK_FIX, 3'h0, 1'b1, 1'b0, 5'h0);
		clr();
		wcount();
		tk(14);
		setv(16'h0005, 16'h0005);
		cfg(TCC_CLK_FIX, 3'h0, 1'b0, 1'b0, 5'h0);
		clr();
		wcount();
		tk(1);
		clr();
		tk(2);
		setv(16'h0000, 16'h0000);
		cfg(TCC_CLK_FIX, 3'h0, 1'b0, 1'b1, 5'h0);
		wcount();
		tk(3);
		setv(16'h0000, 16'h0003);
		tk(4);
		setv(16'hfff0, 16'hffff);
		cfg(TCC_CLK_FIX, 3'h0, 1'b0, 1'b0, 5'h0);
		clr();
		wcount();
		tk(20);
		setv(16'h0000, 16'hffff);
		cfg(TCC_CLK_FIX, 3'h0, 1'b0, 1'b1, 5'h0);
		wcount();
		tk(5);
		setv(16'h0000, 16'h0001);
		cfg(TCC_CLK_FIX, 3'h0, 1'b0, 1'b0, 5'h2);
		clr();
		wcount();
		repeat (4) begin
			tk(6);
			clr();
		end
		setv(16'h0002, 16'h0007);
		cfg(TCC_CLK_FIX, 3'h0, 1'b0, 1'b0, 5'h0);
		wcount();
		tk(3);
		@(posedge clk);
		sync <= 1'b1;
		cnt = ini;
		pre = 0;
		chx++;
		note(cnt, 8'h0);
		@(posedge clk);
		sync <= 1'b0;
		tk(2);
		cfg(TCC_CLK_EXT, 3'h0, 1'b0, 1'b0, 5'h0);
		tk(5);
		// Modulo count to 3 on the system source, divided by four: notes go in before the clock starts
		setv(16'h0000, 16'h0003);
		cfg(TCC_CLK_NONE, 3'h2, 1'b0, 1'b0, 5'h0);
		wcount();
		step(8'h0);
		repeat (10) step(8'h4);
		src = TCC_CLK_SYS;
		apb(1'b1, TCC_CTRL_OFS, {20'h0, tcc_ctrl_t'{5'h0, 1'b0, 1'b0, 3'h2, TCC_CLK_SYS}});
		n = 0;
		while (cq.size() > 0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk_on = 1'b0;
		// Clock enable low must freeze the running counter
		@(posedge clk);
		cen <= 1'b0;
		@(negedge clk);
		lastv = cnt_o;
		repeat (8) @(negedge clk);
		cmp("frozen count", {16'h0, lastv}, {16'h0, cnt_o});
		@(posedge clk);
		cen <= 1'b1;
		repeat (20) @(negedge clk);
		cmp("reload pulses", chx, ch_n);
		cmp("pending notes", 0, cq.size() + fq.size() + rq.size());
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test();
	end
endmodule
